//--- rtl/dpt_target.sv
// serial command target of the 256-position digital potentiometer
// Behaviour
// - start condition opens a transfer
// - address byte: seven address bits, direction
// - address pins sampled once, decoded
// - matching address acknowledged, others ignore
// - instruction: three command bits, zero pad
// - codes 0,1,2 pick wiper, memory, protect
// - nop, restore, store codes
// - data byte msb first, acknowledged
// - protect data sets flag from lsb
// - store and restore carry no data
// - restore holds read power until nop
// - dummy write selects read pointer
// - read byte shifted out after falling clock
// - tolerance readable singly or as pair
// - stop releases bus, ends transfer
// - every wiper data byte updates wiper while protect is clear
// - wiper read repeats per byte
// - data sampled on rising clock
// - protect cleared at power up
// - wiper and memory set to midscale at power up
// - wiper is eight bits
module dpt_target
(
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	// address straps
	input wire logic addr_select_0_in,
	input wire logic addr_select_1_in,
	// tolerance bytes
	input wire logic [7:0] tol_int_in,
	input wire logic [7:0] tol_dec_in,
	// state seen by the analog side
	output logic [7:0] wiper_setting_register_out,
	output logic [7:0] stored_setting_memory_out,
	output logic protect_out,
	output logic read_power_out
);
	typedef struct packed
	{
		dpt_pkg::dpt_state_e state;
		logic [3:0] bitcnt;
		logic [7:0] shift;
		logic rw;
		logic [2:0] cmd;
		logic [2:0] ptr;
		logic [6:0] addr;
		logic strapped;
		logic [7:0] wiper;
		logic [7:0] mem;
		logic prot;
		logic rdpow;
		logic sda_low;
		logic ack_ok;
		logic second;
		logic [1:0] sel_meta;
		logic [1:0] sel_sync;
		logic [1:0] sel_valid;
	} dpt_top_s;
	dpt_top_s r;
	dpt_top_s next_r;
	dpt_pkg::dpt_line_s line;
	logic [6:0] decoded;
	logic [7:0] rbyte;
	logic [7:0] byte_in;
	dpt_line_sync u_sync
	(
		.clock_in(clock_in),
		.rst_in(rst_in),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.line_out(line)
	);
	always_comb
	begin
		case (r.sel_sync)
			2'b00: decoded = dpt_pkg::ADDR_00;
			2'b10: decoded = dpt_pkg::ADDR_10;
			2'b01: decoded = dpt_pkg::ADDR_01;
			default: decoded = dpt_pkg::ADDR_11;
		endcase
	end
	always_comb
	begin
		case (r.ptr)
			dpt_pkg::CMD_MEM: rbyte = r.mem;
			dpt_pkg::CMD_PROT: rbyte = {7'h00, r.prot};
			dpt_pkg::CMD_TOL: rbyte = r.second ? tol_dec_in : tol_int_in;
			dpt_pkg::CMD_TOL2: rbyte = tol_dec_in;
			default: rbyte = r.wiper;
		endcase
	end
	assign byte_in = {r.shift[6:0], line.sda};
	always_comb
	begin
		next_r = r;
		next_r.sel_meta = {addr_select_1_in, addr_select_0_in};
		next_r.sel_sync = r.sel_meta;
		next_r.sel_valid = {r.sel_valid[0], 1'b1};
		if (!r.strapped && r.sel_valid[1])
		begin
			next_r.strapped = 1'b1;
			next_r.addr = decoded;
		end
		if (line.start)
		begin
			next_r.state = dpt_pkg::ST_ADDR;
			next_r.bitcnt = dpt_pkg::BIT_ZERO;
			next_r.sda_low = 1'b0;
			next_r.second = 1'b0;
		end
		else if (line.stop)
		begin
			next_r.state = dpt_pkg::ST_IDLE;
			next_r.sda_low = 1'b0;
		end
		else if (r.state != dpt_pkg::ST_IDLE && r.state != dpt_pkg::ST_SKIP)
		begin
			if (line.rise && r.bitcnt != dpt_pkg::BIT_ACK)
			begin
				next_r.shift = byte_in;
				next_r.bitcnt = r.bitcnt + 4'h1;
				if (r.bitcnt == dpt_pkg::BIT_LAST)
				begin
					next_r.ack_ok = 1'b1;
					case (r.state)
						dpt_pkg::ST_ADDR:
						begin
							next_r.rw = line.sda;
							next_r.ack_ok = byte_in[7:1] == r.addr;
						end
						dpt_pkg::ST_INSTR:
						begin
							next_r.cmd = byte_in[7:5];
							next_r.ack_ok = byte_in[4:0] == dpt_pkg::PAD_ZERO;
						end
						dpt_pkg::ST_WDATA:
						begin
							case (r.cmd)
								dpt_pkg::CMD_WIPER:
									if (!r.prot)
										next_r.wiper = byte_in;
								dpt_pkg::CMD_MEM:
									if (!r.prot)
										next_r.mem = byte_in;
								dpt_pkg::CMD_PROT: next_r.prot = byte_in[0];
								default: next_r.ack_ok = 1'b1;
							endcase
						end
						default: next_r.ack_ok = 1'b1;
					endcase
				end
			end
			else if (line.rise)
			begin
				next_r.bitcnt = dpt_pkg::BIT_ZERO;
				case (r.state)
					dpt_pkg::ST_ADDR:
						if (!r.ack_ok)
							next_r.state = dpt_pkg::ST_SKIP;
						else if (r.rw)
							next_r.state = dpt_pkg::ST_RDATA;
						else
							next_r.state = dpt_pkg::ST_INSTR;
					dpt_pkg::ST_INSTR:
					begin
						next_r.state = r.ack_ok ? dpt_pkg::ST_WDATA : dpt_pkg::ST_SKIP;
						if (r.ack_ok)
						begin
							case (r.cmd)
								dpt_pkg::CMD_WIPER, dpt_pkg::CMD_MEM, dpt_pkg::CMD_PROT,
								dpt_pkg::CMD_TOL, dpt_pkg::CMD_TOL2:
									next_r.ptr = r.cmd;
								dpt_pkg::CMD_NOP: next_r.rdpow = 1'b0;
								dpt_pkg::CMD_RESTORE:
								begin
									next_r.wiper = r.mem;
									next_r.rdpow = 1'b1;
								end
								dpt_pkg::CMD_STORE:
									if (!r.prot)
										next_r.mem = r.wiper;
								default: next_r.ptr = r.ptr;
							endcase
						end
					end
					dpt_pkg::ST_RDATA:
					begin
						next_r.state = line.sda ? dpt_pkg::ST_SKIP : dpt_pkg::ST_RDATA;
						next_r.second = 1'b1;
					end
					default: next_r.state = r.state;
				endcase
			end
			if (line.fall)
			begin
				if (r.state == dpt_pkg::ST_RDATA && r.bitcnt != dpt_pkg::BIT_ACK)
					next_r.sda_low = !rbyte[3'(dpt_pkg::BIT_LAST - r.bitcnt)];
				else if (r.bitcnt == dpt_pkg::BIT_ACK && r.ack_ok)
					next_r.sda_low = r.state != dpt_pkg::ST_RDATA;
				else
					next_r.sda_low = 1'b0;
			end
		end
		else
			next_r.sda_low = 1'b0;
		// first read bit is driven right after the address ack ends
		if (line.fall && r.state == dpt_pkg::ST_RDATA && r.bitcnt == dpt_pkg::BIT_ZERO && r.ack_ok)
			next_r.sda_low = !rbyte[7];
	end
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			r.state <= dpt_pkg::ST_IDLE;
			r.bitcnt <= dpt_pkg::BIT_ZERO;
			r.shift <= 8'h00;
			r.rw <= 1'b0;
			r.cmd <= dpt_pkg::CMD_WIPER;
			r.ptr <= dpt_pkg::CMD_WIPER;
			r.addr <= dpt_pkg::ADDR_00;
			r.strapped <= 1'b0;
			r.wiper <= dpt_pkg::MIDSCALE;
			r.mem <= dpt_pkg::MIDSCALE;
			r.prot <= 1'b0;
			r.rdpow <= 1'b0;
			r.sda_low <= 1'b0;
			r.ack_ok <= 1'b0;
			r.second <= 1'b0;
			r.sel_meta <= 2'b00;
			r.sel_sync <= 2'b00;
			r.sel_valid <= 2'b00;
		end
		else
			r <= next_r;
	end
	assign sda_out = 1'b0;
	assign sda_oe_out = r.sda_low;
	assign wiper_setting_register_out = r.wiper;
	assign stored_setting_memory_out = r.mem;
	assign protect_out = r.prot;
	assign read_power_out = r.rdpow;
	sequence stop_seen_s;
		line.stop;
	endsequence
	stop_release_a: assert property (@(posedge clock_in) disable iff (rst_in) stop_seen_s |=> !sda_oe_out)
		else $error("bus held after stop");
	start_addr_a: assert property (@(posedge clock_in) disable iff (rst_in) line.start |=> r.state == dpt_pkg::ST_ADDR)
		else $error("start not taken");
	prot_block_a: assert property (@(posedge clock_in) disable iff (rst_in)
		r.prot && r.state == dpt_pkg::ST_WDATA && r.cmd == dpt_pkg::CMD_WIPER |=> $stable(r.wiper))
		else $error("wiper written while protected");
	restore_copy_a: assert property (@(posedge clock_in) disable iff (rst_in)
		$rose(r.rdpow) |-> r.wiper == $past(r.mem))
		else $error("restore did not copy");
	strap_once_a: assert property (@(posedge clock_in) disable iff (rst_in) r.strapped |=> $stable(r.addr))
		else $error("address changed after power up");
	skip_quiet_a: assert property (@(posedge clock_in) disable iff (rst_in) r.state == dpt_pkg::ST_SKIP |=> !sda_oe_out)
		else $error("unaddressed target drives bus");
	mem_prot_a: assert property (@(posedge clock_in) disable iff (rst_in) r.prot && !line.start |=> $stable(r.mem))
		else $error("memory written while protected");
	nop_idle_a: assert property (@(posedge clock_in) disable iff (rst_in)
		$fell(r.rdpow) |-> $past(r.cmd) == dpt_pkg::CMD_NOP)
		else $error("read power left without nop");
	sequence ack_slot_s;
		line.fall && r.bitcnt == dpt_pkg::BIT_ACK && r.ack_ok &&
		(r.state == dpt_pkg::ST_ADDR || r.state == dpt_pkg::ST_INSTR || r.state == dpt_pkg::ST_WDATA);
	endsequence
	ack_drive_a: assert property (@(posedge clock_in) disable iff (rst_in) ack_slot_s |=> sda_oe_out)
		else $error("acknowledge not driven");
	sequence read_first_s;
		line.fall && r.state == dpt_pkg::ST_RDATA && r.bitcnt == dpt_pkg::BIT_ZERO;
	endsequence
	read_msb_a: assert property (@(posedge clock_in) disable iff (rst_in)
		read_first_s |=> sda_oe_out != $past(rbyte[7]))
		else $error("read msb not driven");
	idle_quiet_a: assert property (@(posedge clock_in) disable iff (rst_in)
		r.state == dpt_pkg::ST_IDLE |=> !sda_oe_out)
		else $error("idle target drives bus");
	sequence wiper_byte_s;
		line.rise && r.state == dpt_pkg::ST_WDATA && r.bitcnt == dpt_pkg::BIT_LAST &&
		r.cmd == dpt_pkg::CMD_WIPER && !r.prot;
	endsequence
	wiper_load_a: assert property (@(posedge clock_in) disable iff (rst_in)
		wiper_byte_s |=> r.wiper == $past(byte_in))
		else $error("wiper byte not taken");
	sequence prot_byte_s;
		line.rise && r.state == dpt_pkg::ST_WDATA && r.bitcnt == dpt_pkg::BIT_LAST && r.cmd == dpt_pkg::CMD_PROT;
	endsequence
	prot_load_a: assert property (@(posedge clock_in) disable iff (rst_in)
		prot_byte_s |=> r.prot == $past(line.sda))
		else $error("protect bit not taken");
endmodule

//--- inc/dpt_pkg.sv
// package of constants and carriers for the digipot serial target
package dpt_pkg;
	localparam logic [6:0] ADDR_00 = 7'h18;
	localparam logic [6:0] ADDR_10 = 7'h1a;
	localparam logic [6:0] ADDR_01 = 7'h4c;
	localparam logic [6:0] ADDR_11 = 7'h4e;
	localparam logic [2:0] CMD_WIPER = 3'h0;
	localparam logic [2:0] CMD_MEM = 3'h1;
	localparam logic [2:0] CMD_PROT = 3'h2;
	localparam logic [2:0] CMD_NOP = 3'h4;
	localparam logic [2:0] CMD_RESTORE = 3'h5;
	localparam logic [2:0] CMD_STORE = 3'h6;
	localparam logic [2:0] CMD_TOL = 3'h3;
	localparam logic [2:0] CMD_TOL2 = 3'h7;
	localparam logic [7:0] MIDSCALE = 8'h80;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ZERO = 4'h0;
	localparam logic [4:0] PAD_ZERO = 5'h00;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_INSTR = 3'b010,
		ST_WDATA = 3'b011,
		ST_RDATA = 3'b100,
		ST_SKIP = 3'b101
	} dpt_state_e;
	typedef struct packed
	{
		logic start;
		logic stop;
		logic rise;
		logic fall;
		logic sda;
	} dpt_line_s;
endpackage

//--- rtl/dpt_line_sync.sv
// synchroniser and condition detector for the two bus lines
module dpt_line_sync
(
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// pins
	input wire logic scl_in,
	input wire logic sda_in,
	// events
	output dpt_pkg::dpt_line_s line_out
);
	typedef struct packed
	{
		logic [1:0] scl_meta;
		logic [1:0] sda_meta;
		logic scl_old;
		logic sda_old;
	} dpt_sync_s;
	dpt_sync_s r;
	dpt_sync_s next_r;
	always_comb
	begin
		next_r = r;
		next_r.scl_meta = {r.scl_meta[0], scl_in};
		next_r.sda_meta = {r.sda_meta[0], sda_in};
		next_r.scl_old = r.scl_meta[1];
		next_r.sda_old = r.sda_meta[1];
	end
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			r <= '{2'b11, 2'b11, 1'b1, 1'b1};
		else
			r <= next_r;
	end
	always_comb
	begin
		line_out.start = r.scl_meta[1] && r.scl_old && r.sda_old && !r.sda_meta[1];
		line_out.stop = r.scl_meta[1] && r.scl_old && !r.sda_old && r.sda_meta[1];
		line_out.rise = r.scl_meta[1] && !r.scl_old;
		line_out.fall = !r.scl_meta[1] && r.scl_old;
		line_out.sda = r.sda_meta[1];
	end
endmodule

//--- tb/dpt_host.sv
// bus master model for the digipot target
module dpt_host
(
	// clock
	input wire logic clock_in,
	// bus lines
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clock_in);
	endtask
	task automatic start;
		sda_out <= 1'b1;
		wt(2);
		scl_out <= 1'b1;
		wt(4);
		sda_out <= 1'b0;
		wt(4);
		scl_out <= 1'b0;
		wt(2);
	endtask
	task automatic stop;
		sda_out <= 1'b0;
		wt(2);
		scl_out <= 1'b1;
		wt(4);
		sda_out <= 1'b1;
		wt(8);
	endtask
	task automatic bx(input logic b, output logic r);
		sda_out <= b;
		wt(2);
		scl_out <= 1'b1;
		wt(4);
		r = sda_in;
		scl_out <= 1'b0;
		wt(2);
	endtask
	task automatic wr(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bx(b[i], r);
		bx(1'b1, r);
		ack = ~r;
	endtask
	task automatic rd(input logic last, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--)
			bx(1'b1, v[i]);
		bx(last, r);
	endtask
endmodule

//--- tb/dpt_target_test.sv
// self-checking bench for the digipot serial target
module dpt_target_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] tol_int = 8'h00;
	logic [7:0] tol_dec = 8'h00;
	logic [1:0] sel = 2'b00;
	logic scl, hsda, dsda, doe, prot, rpw;
	logic [7:0] wip, mem, we, wg, r1, r2, r3, r4;
	wire bus = hsda & (doe ? dsda : 1'b1);
	logic [31:0] seed = 32'h7289;
	logic [7:0] exp_q[$];
	logic [7:0] obs_q[$];
	event got_ev;
	int error_cnt = 0;
	int samples_checked = 0;
	dpt_target i_dut
	(
		.clock_in(clock_in),
		.rst_in(rst_in),
		.scl_in(scl),
		.sda_in(bus),
		.sda_out(dsda),
		.sda_oe_out(doe),
		.addr_select_0_in(sel[0]),
		.addr_select_1_in(sel[1]),
		.tol_int_in(tol_int),
		.tol_dec_in(tol_dec),
		.wiper_setting_register_out(wip),
		.stored_setting_memory_out(mem),
		.protect_out(prot),
		.read_power_out(rpw)
	);
	dpt_host i_host
	(
		.clock_in(clock_in),
		.sda_in(bus),
		.scl_out(scl),
		.sda_out(hsda)
	);
	initial forever #5 clock_in = ~clock_in;
	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		exp_q.push_back(e);
		obs_q.push_back(g);
		-> got_ev;
	endtask
	initial
	forever
	begin
		@(got_ev);
		while (obs_q.size() > 0)
		begin
			we = exp_q.pop_front();
			wg = obs_q.pop_front();
			samples_checked++;
			if (wg !== we)
			begin
				error_cnt++;
				$display("wrong value at %0t: expected %h, got %h", $time, we, wg);
			end
		end
	end
	task automatic cmd(input logic [7:0] adr, ins, d0, input int nd, input logic ea, ei);
		logic a;
		i_host.start();
		i_host.wr(adr, a);
		chk(ea, a);
		i_host.wr(ins, a);
		chk(ei, a);
		for (int i = 0; i < nd; i++)
		begin
			i_host.wr(d0 + i[7:0], a);
			chk(ei, a);
			if (ins === 8'h00 && nd == 2)
				chk(d0 + i[7:0], wip);
		end
		i_host.stop();
	endtask
	task automatic rdx(input logic [7:0] ins, e0, e1, input int n);
		logic a;
		logic [7:0] v;
		i_host.start();
		i_host.wr(8'h30, a);
		i_host.wr(ins, a);
		i_host.start();
		i_host.wr(8'h31, a);
		chk(8'h01, a);
		i_host.rd(n == 1, v);
		chk(e0, v);
		if (n == 2)
		begin
			i_host.rd(1'b1, v);
			chk(e1, v);
		end
		i_host.stop();
	endtask
	task automatic results;
		$display("checks %0d, errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (30000) @(posedge clock_in);
		error_cnt++;
		results();
	end
	initial
	begin
		repeat (6) @(posedge clock_in);
		rst_in <= 1'b0;
		tol_int <= xs();
		tol_dec <= xs();
		i_host.wt(5);
		chk(8'h80, wip);
		chk(8'h80, mem);
		chk(8'h00, {7'h00, prot});
		r1 = xs();
		r2 = xs();
		r3 = xs();
		r4 = xs();
		cmd(8'h30, 8'h00, r1, 2, 1'b1, 1'b1);
		rdx(8'h00, r1 + 8'h01, r1 + 8'h01, 2);
		cmd(8'h30, 8'h20, r2, 1, 1'b1, 1'b1);
		chk(r2, mem);
		rdx(8'h20, r2, r2, 1);
		cmd(8'h30, 8'hc0, r2, 0, 1'b1, 1'b1);
		chk(r1 + 8'h01, mem);
		cmd(8'h30, 8'h20, r3, 1, 1'b1, 1'b1);
		cmd(8'h30, 8'ha0, r3, 0, 1'b1, 1'b1);
		chk(r3, wip);
		chk(8'h01, {7'h00, rpw});
		cmd(8'h30, 8'h80, r3, 0, 1'b1, 1'b1);
		chk(8'h00, {7'h00, rpw});
		cmd(8'h30, 8'h40, 8'h01, 1, 1'b1, 1'b1);
		chk(8'h01, {7'h00, prot});
		rdx(8'h40, 8'h01, 8'h01, 1);
		cmd(8'h30, 8'h00, r4, 1, 1'b1, 1'b1);
		chk(r3, wip);
		cmd(8'h30, 8'h40, 8'h00, 1, 1'b1, 1'b1);
		chk(8'h00, {7'h00, prot});
		cmd(8'h34, 8'h00, r4, 1, 1'b0, 1'b0);
		cmd(8'h30, 8'h01, r4, 1, 1'b1, 1'b0);
		chk(r3, wip);
		rdx(8'h60, tol_int, tol_dec, 2);
		rdx(8'he0, tol_dec, tol_dec, 1);
		cmd(8'h30, 8'h40, 8'h01, 1, 1'b1, 1'b1);
		rst_in <= 1'b1;
		sel <= 2'b11;
		i_host.wt(6);
		rst_in <= 1'b0;
		i_host.wt(5);
		chk(8'h00, {7'h00, prot});
		chk(8'h80, wip);
		cmd(8'h9c, 8'h00, r4, 1, 1'b1, 1'b1);
		chk(r4, wip);
		cmd(8'h30, 8'h00, ~r4, 1, 1'b0, 1'b0);
		chk(r4, wip);
		i_host.wt(4);
		results();
	end
endmodule
